//--- hdl/cts_top.sv
// charge sequencer, safety timers, recharge, adaptive limit, apb regs
//
// Register access over APB and the address map were chosen for this implementation.
`timescale 1ns/100ps
module cts_top
  import cts_pkg::*;
#(
  parameter int     DEGLITCH_CYC = CTS_DEGLITCH_CYC,
  parameter longint MIN_CYC      = CTS_MIN_CYC
) (
  input  wire logic        clk_i,            // 125 MHz
  input  wire logic        resetn_i,         // async, low; rail uvlo
  input  wire logic        psel_i,           // apb select
  input  wire logic        penable_i,        // apb enable
  input  wire logic        pwrite_i,         // apb write
  input  wire logic [7:0]  paddr_i,          // apb byte address
  input  wire logic [31:0] pwdata_i,         // apb write data
  output logic      [31:0] prdata_o,         // apb read data
  output logic             pready_o,         // apb ready
  output logic             pslverr_o,        // apb error
  input  wire logic        charge_disable_pin_i, // high disables
  input  wire logic        battery_absent_pin_i, // high: no battery
  input  wire logic        input_valid_i,    // input supply valid
  input  wire logic        input_uvlo_i,     // input below uvlo
  input  wire logic        input_ovp_i,      // input overvoltage
  input  wire logic        bat_ovp_i,        // battery overvoltage
  input  wire logic        thermal_sd_i,     // thermal shutdown
  input  wire logic        bat_above_trickle_i, // above trickle level
  input  wire logic        bat_above_min_i,  // above min_system_voltage
  input  wire logic        bat_at_reg_i,     // at regulation voltage
  input  wire logic        i_at_topoff_i,    // current at topoff level
  input  wire logic        bat_below_rch_i,  // below recharge_threshold
  input  wire logic        input_sag_i,      // at input_sag_threshold
  input  wire logic        ilim_hit_i,       // input current limit hit
  input  wire logic        rail_below_bat_i, // rail 50 mV under battery
  input  wire logic        ichg_zero_i,      // charge current is zero
  output logic             charge_on_o,      // charger switching
  output logic             fast_mode_o,      // constant current
  output logic             cv_mode_o,        // constant voltage
  output logic             soft_start_o,     // soft ramp active
  output logic             rail_boot_o,      // rail regulated 3.6 V
  output logic             rail_hold_o,      // charge cut, rail 3.4 V
  output logic             supplement_o,     // battery feeds rail
  output logic      [7:0]  in_limit_o,       // limit in 25 mA steps
  output logic             irq_out_n_o       // interrupt, active low
);
  localparam int NSYNC = 15;
  localparam int DG_W = 32;

  typedef struct packed {
    logic [NSYNC-1:0] s1;
    logic [NSYNC-1:0] s2;
    cts_state_e       st;
    logic [1:0]       ctrl;
    logic [7:0]       ss_div;
    logic [15:0]      fast_min;
    logic [15:0]      top_min;
    logic [7:0]       lim_max;
    logic [CTS_NEV-1:0] flags;
    logic [CTS_NEV-1:0] mask;
    logic [32:0]      mcnt;
    logic             mtick;
    logic [DG_W-1:0]  dg;
    logic             rch_ok;
    logic [15:0]      pre_t;
    logic [15:0]      fast_t;
    logic [15:0]      top_t;
    logic [15:0]      sscnt;
    logic [7:0]       sstep;
    logic             sstick;
    logic [7:0]       lim;
    logic             ovld;
    logic             abs_d;
    logic             recharge;
    logic [31:0]      rdata;
  } cts_state_s;

  cts_state_s r, n;
  logic [NSYNC-1:0] raw;
  logic [CTS_NEV-1:0] ev;
  logic en, fault, wr, rd, rd_setup, tick, ss_hit, mapped;

  assign raw = {charge_disable_pin_i, battery_absent_pin_i, input_valid_i,
                input_uvlo_i, input_ovp_i, bat_ovp_i, thermal_sd_i,
                bat_above_trickle_i, bat_above_min_i, bat_at_reg_i,
                i_at_topoff_i, bat_below_rch_i, input_sag_i, ilim_hit_i,
                rail_below_bat_i};
  // s2 index: 14 dis,13 abs,12 valid,11 uvlo,10 iovp,9 bovp,8 tsd,
  // 7 trk,6 min,5 reg,4 topi,3 rch,2 sag,1 ilim,0 railbelow

  assign wr = psel_i & penable_i & pwrite_i;
  assign rd = psel_i & penable_i & ~pwrite_i;
  assign rd_setup = psel_i & ~penable_i & ~pwrite_i;
  assign pready_o = 1'b1;
  assign mapped = paddr_i inside {CTS_CTRL_ADDR, CTS_TIMER_ADDR,
                  CTS_STATUS_ADDR, CTS_IRQ_ADDR, CTS_MASK_ADDR,
                  CTS_LIMIT_ADDR};
  assign pslverr_o = psel_i & penable_i & ~mapped;
  assign prdata_o = r.rdata;

  always_comb begin
    n = r;
    ev = '0;
    //==============================================================
    // synchronisers; first stage feeds only the second
    n.s1 = raw;
    n.s2 = r.s1;
    en = r.ctrl[CTS_CTRL_EN_BIT] & ~r.s2[14];
    fault = r.s2[9] | r.s2[10] | r.s2[8];
    //==============================================================
    // prescaler: one pulse per minute drives the precharge, fast and topoff timers
    n.mtick = 1'b0;
    if (r.mcnt >= 33'(MIN_CYC - 1)) begin
      n.mcnt = '0;
      n.mtick = 1'b1;
    end else begin
      n.mcnt = r.mcnt + 33'h1;
    end
    tick = r.mtick;
    //==============================================================
    // soft-start clock, period ss_div plus one units of 10 us
    n.sstick = 1'b0;
    if (r.sscnt >= 16'(CTS_SS_UNIT_CYC - 1)) begin
      n.sscnt = '0;
      if (r.sstep >= r.ss_div) begin
        n.sstep = '0;
        n.sstick = 1'b1;
      end else begin
        n.sstep = r.sstep + 8'h1;
      end
    end else begin
      n.sscnt = r.sscnt + 16'h1;
    end
    //==============================================================
    // recharge qualification: threshold sits fixed below regulation
    n.rch_ok = 1'b0;
    if (!r.s2[3]) begin
      n.dg = '0;
    end else if (r.dg >= DG_W'(DEGLITCH_CYC - 1)) begin
      n.rch_ok = 1'b1;
    end else begin
      n.dg = r.dg + DG_W'(1);
    end
    //==============================================================
    // adaptive input limit, one 25 mA code per soft-start tick
    if (!r.s2[12] || r.s2[11]) begin
      n.lim = '0;
    end else if (r.sstick) begin
      if (r.s2[2] && r.lim != 8'h0) begin
        n.lim = r.lim - 8'h1;
      end else if (r.lim < r.lim_max && !r.s2[1]) begin
        n.lim = r.lim + 8'h1;
      end
    end
    //==============================================================
    // charge state machine
    case (r.st)
      CTS_IDLE: begin
        if (en && r.s2[12] && !fault && !r.s2[13] && !r.s2[11]) begin
          n.st = r.recharge ? CTS_FAST : CTS_TRICKLE;
        end
      end
      CTS_TRICKLE: begin
        if (r.s2[7]) begin
          n.st = CTS_PRE;
        end
      end
      CTS_PRE: begin
        if (r.s2[6]) begin
          n.st = CTS_SOFT;
        end else if (r.pre_t >= 16'(CTS_PRE_MIN)) begin
          n.st = CTS_SUSP;
          ev[CTS_EV_FAULT] = 1'b1;
        end
      end
      CTS_SOFT: begin
        if (r.sstick) begin
          n.st = CTS_FAST;
        end
      end
      CTS_FAST: begin
        if (r.s2[5] && r.s2[4]) begin
          n.st = CTS_TOPOFF;
          ev[CTS_EV_TOPOFF] = 1'b1;
        end else if (r.fast_min != 16'h0 &&
                     r.fast_t >= r.fast_min) begin
          n.st = CTS_SUSP;
          ev[CTS_EV_FAULT] = 1'b1;
        end
      end
      CTS_TOPOFF: begin
        if (r.top_t >= r.top_min) begin
          ev[CTS_EV_DONE] = 1'b1;
          n.st = CTS_DONE;
        end
      end
      CTS_DONE: begin
        if (r.ctrl[CTS_CTRL_AUTO_BIT] && r.rch_ok) begin
          n.st = CTS_FAST;
          ev[CTS_EV_RECHG] = 1'b1;
        end
      end
      CTS_SUSP: begin
        if (!en) begin
          n.st = CTS_IDLE;
        end
      end
      default: n.st = CTS_IDLE;
    endcase
    if (r.st == CTS_TOPOFF && r.rch_ok) begin
      n.st = CTS_FAST;
      ev[CTS_EV_RECHG] = 1'b1;
    end
    // topoff or done reached arms a recharge start on re-enable
    if (r.st == CTS_TOPOFF || r.st == CTS_DONE) begin
      n.recharge = 1'b1;
    end else if (r.st == CTS_FAST || r.st == CTS_TRICKLE) begin
      n.recharge = 1'b0;
    end
    if (r.st != CTS_IDLE && r.st != CTS_SUSP &&
        (!en || fault || r.s2[11] || !r.s2[12])) begin
      n.st = CTS_IDLE;
    end
    if (r.s2[13]) begin
      n.st = CTS_IDLE;
    end
    // rising edge of the synchronised pin; the first stage stays private
    n.abs_d = r.s2[13];
    ev[CTS_EV_ABSENT] = r.s2[13] & ~r.abs_d;
    //==============================================================
    // safety timers
    if (fault || r.s2[11] || r.s2[14] || r.s2[6] ||
        r.st != CTS_PRE) begin
      n.pre_t = '0;
    end else if (tick) begin
      n.pre_t = r.pre_t + 16'h1;
    end
    if (fault || r.s2[11] || !en || r.st != CTS_FAST) begin
      n.fast_t = '0;
    end else if (tick) begin
      n.fast_t = r.fast_t + 16'h1;
    end
    if (fault || r.s2[11] || !en || r.st != CTS_TOPOFF) begin
      n.top_t = '0;
    end else if (tick) begin
      n.top_t = r.top_t + 16'h1;
    end
    //==============================================================
    // system rail priority and overload
    n.ovld = (r.st == CTS_FAST || r.st == CTS_TOPOFF ||
              r.st == CTS_SOFT) && r.s2[1] && r.s2[0] && ichg_zero_i;
    ev[CTS_EV_OVLD] = n.ovld & ~r.ovld;
    //==============================================================
    // apb registers; set beats read-clear
    // read data is latched in setup so it stands through the access cycle
    n.rdata = '0;
    if (rd_setup) begin
      case (paddr_i)
        CTS_CTRL_ADDR:   n.rdata = {16'h0, r.ss_div, 6'h0, r.ctrl};
        CTS_TIMER_ADDR:  n.rdata = {r.top_min, r.fast_min};
        CTS_STATUS_ADDR: n.rdata = {22'h0, r.ovld, r.recharge, r.lim[0],
                                    r.s2[13], r.s2[14], 2'h0, r.st};
        CTS_IRQ_ADDR:    n.rdata = {26'h0, r.flags};
        CTS_MASK_ADDR:   n.rdata = {26'h0, r.mask};
        CTS_LIMIT_ADDR:  n.rdata = {16'h0, r.lim, r.lim_max};
        default:         n.rdata = '0;
      endcase
    end
    if (rd && paddr_i == CTS_IRQ_ADDR) begin
      // only the bits this read reported are cleared
      n.flags = (r.flags & ~r.rdata[CTS_NEV-1:0]) | ev;
    end else begin
      n.flags = r.flags | ev;
    end
    if (wr) begin
      case (paddr_i)
        CTS_CTRL_ADDR: begin
          n.ctrl = pwdata_i[1:0];
          n.ss_div = pwdata_i[CTS_CTRL_SS_LSB +: 8];
        end
        CTS_TIMER_ADDR: begin
          n.fast_min = pwdata_i[15:0];
          n.top_min = pwdata_i[31:16];
        end
        CTS_MASK_ADDR:  n.mask = pwdata_i[CTS_NEV-1:0];
        CTS_LIMIT_ADDR: n.lim_max = pwdata_i[7:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      r <= '0;
      r.ctrl <= CTS_CTRL_RST;
      r.ss_div <= CTS_SS_RST;
      r.fast_min <= CTS_FAST_RST;
      r.top_min <= CTS_TOPOFF_RST;
      r.lim_max <= CTS_LIMIT_RST;
    end else begin
      r <= n;
    end
  end

  //==============================================================
  // outputs
  assign ss_hit = r.st == CTS_SOFT;
  assign charge_on_o = r.st != CTS_IDLE && r.st != CTS_SUSP &&
                       !(r.st == CTS_DONE &&
                         r.ctrl[CTS_CTRL_AUTO_BIT]);
  assign fast_mode_o = r.st == CTS_FAST || ss_hit;
  assign cv_mode_o = r.st == CTS_TOPOFF ||
                     (r.st == CTS_DONE && !r.ctrl[CTS_CTRL_AUTO_BIT]);
  assign soft_start_o = ss_hit;
  assign rail_boot_o = r.st == CTS_TRICKLE || r.st == CTS_PRE;
  assign rail_hold_o = charge_on_o && r.s2[1];
  assign supplement_o = r.ovld;
  assign in_limit_o = r.lim;
  assign irq_out_n_o = ~|(r.flags & ~r.mask);
endmodule

//--- hdl/cts_pkg.sv
// constants and types of the charge timer and sequencer block
//==============================================================
package cts_pkg;
  //==============================================================
  // register map on apb
  localparam logic [7:0] CTS_CTRL_ADDR   = 8'h00;
  localparam logic [7:0] CTS_TIMER_ADDR  = 8'h04;
  localparam logic [7:0] CTS_STATUS_ADDR = 8'h08;
  localparam logic [7:0] CTS_IRQ_ADDR    = 8'h0c;
  localparam logic [7:0] CTS_MASK_ADDR   = 8'h10;
  localparam logic [7:0] CTS_LIMIT_ADDR  = 8'h14;
  // control fields
  localparam int CTS_CTRL_EN_BIT   = 0;
  localparam int CTS_CTRL_AUTO_BIT = 1;
  localparam int CTS_CTRL_SS_LSB   = 8;
  localparam logic [1:0] CTS_CTRL_RST = 2'h3;
  localparam logic [7:0] CTS_SS_RST   = 8'h0f;
  localparam logic [15:0] CTS_FAST_RST   = 16'h00b4;
  localparam logic [15:0] CTS_TOPOFF_RST = 16'h002d;
  localparam logic [7:0] CTS_LIMIT_RST  = 8'h14;
  // event bits
  localparam int CTS_EV_RECHG = 0;
  localparam int CTS_EV_ABSENT = 1;
  localparam int CTS_EV_FAULT = 2;
  localparam int CTS_EV_TOPOFF = 3;
  localparam int CTS_EV_DONE = 4;
  localparam int CTS_EV_OVLD = 5;
  localparam int CTS_NEV = 6;
  // analog figures
  localparam int CTS_RECHG_OFS_MV = -100;
  localparam int CTS_STEP_MA      = 25;
  localparam int CTS_RAIL_BOOT_MV = 3600;
  localparam int CTS_RAIL_LIM_MV  = 3400;
  localparam int CTS_SUPPL_MV     = 50;
  // timing
  localparam int CTS_CLK_KHZ     = 125000;
  localparam int CTS_DEGLITCH_MS = 27;
  localparam int CTS_DEGLITCH_CYC = CTS_DEGLITCH_MS * CTS_CLK_KHZ;
  localparam int CTS_PRE_MIN     = 45;
  // a minute of clocks does not fit in 32 bits
  localparam longint CTS_MIN_CYC = longint'(60) * 1000 * CTS_CLK_KHZ;
  localparam int CTS_SS_UNIT_US  = 10;
  localparam int CTS_SS_UNIT_CYC = CTS_SS_UNIT_US * CTS_CLK_KHZ / 1000;
  typedef enum logic [2:0] {
    CTS_IDLE    = 3'b000,
    CTS_TRICKLE = 3'b001,
    CTS_PRE     = 3'b011,
    CTS_SOFT    = 3'b010,
    CTS_FAST    = 3'b110,
    CTS_TOPOFF  = 3'b111,
    CTS_DONE    = 3'b101,
    CTS_SUSP    = 3'b100
  } cts_state_e;
endpackage

//--- verif/cts_analog_model.sv
// battery and power stage comparator model for the charge sequencer
`timescale 1ns/100ps
module cts_analog_model
  import cts_pkg::*;
#(
  parameter int REG_MV  = 4200, // regulation point, plain default
  parameter int TRKL_MV = 2500  // trickle exit level
) (
  input  wire logic [15:0] bat_mv_i, // battery voltage in mV
  input  wire logic        taper_i,  // charge current has tapered
  output logic             trkl_o,   // above trickle level
  output logic             min_o,    // above min_system_voltage
  output logic             reg_o,    // at regulation voltage
  output logic             topoff_o, // current at topoff level
  output logic             rch_o     // below recharge_threshold
);
  //==============================================================
  // comparators
  // levels only: the bench moves the battery, the model never glitches
  assign trkl_o   = int'(bat_mv_i) > TRKL_MV;
  assign min_o    = int'(bat_mv_i) >= CTS_RAIL_BOOT_MV;
  assign reg_o    = int'(bat_mv_i) >= REG_MV;
  assign topoff_o = reg_o & taper_i;
  assign rch_o    = int'(bat_mv_i) < REG_MV + CTS_RECHG_OFS_MV;
endmodule

//--- verif/cts_top_props.sv
// concurrent checks on the ports of the charge sequencer
`timescale 1ns/100ps
module cts_top_props (
  input wire logic       clk_i,                // clock
  input wire logic       resetn_i,             // reset, low
  input wire logic       psel_i,               // apb select
  input wire logic       charge_disable_pin_i, // disable pin
  input wire logic       battery_absent_pin_i, // no battery
  input wire logic       thermal_sd_i,         // thermal shutdown
  input wire logic       ilim_hit_i,           // input limit hit
  input wire logic       rail_below_bat_i,     // rail under battery
  input wire logic       charge_on_o,          // charging
  input wire logic       fast_mode_o,          // constant current
  input wire logic       cv_mode_o,            // constant voltage
  input wire logic       rail_boot_o,          // rail at 3.6 V
  input wire logic       rail_hold_o,          // rail held 3.4 V
  input wire logic       supplement_o,         // battery feeds rail
  input wire logic [7:0] in_limit_o,           // input limit code
  input wire logic       irq_out_n_o           // interrupt, low
);
  //==============================================================
  // checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);
  // six cycles leave room for the two-flop sync plus the state register
  pin_blocks_a: assert property (
    charge_disable_pin_i [*6] |-> !charge_on_o)
    else $error("charging while disable pin high");
  absent_stops_a: assert property (
    battery_absent_pin_i [*6] |-> !charge_on_o)
    else $error("charging without battery");
  fault_stops_a: assert property (
    thermal_sd_i [*6] |-> !charge_on_o)
    else $error("charging in thermal shutdown");
  boot_rail_a: assert property (
    rail_boot_o |-> !fast_mode_o && !cv_mode_o)
    else $error("boot rail outside trickle or precharge");
  limit_step_a: assert property (
    $changed(in_limit_o) |-> in_limit_o == $past(in_limit_o) + 8'h01 ||
      in_limit_o == $past(in_limit_o) - 8'h01 || in_limit_o == 8'h00)
    else $error("input limit moved more than one step");
  suppl_cause_a: assert property (
    !rail_below_bat_i [*6] |-> !supplement_o)
    else $error("supplement with rail above battery");
  hold_cause_a: assert property (
    !ilim_hit_i [*6] |-> !rail_hold_o)
    else $error("rail hold without input limit");
  irq_sticky_a: assert property (
    !irq_out_n_o && !psel_i && !$past(psel_i) |=> !irq_out_n_o)
    else $error("interrupt dropped without a read");
endmodule

//--- verif/tb_top.sv
// self-checking bench of the charge timer and sequencer
`timescale 1ns/100ps
module tb_top;
  import cts_pkg::*;
  //==============================================================
  // signals
  localparam int DGL = 50;
  localparam int CHG = 6;
  localparam int FST = 5;
  localparam int CV  = 4;
  localparam int SFT = 3;
  localparam int SUP = 0;
  logic        clk_i = 1'b0;
  logic        resetn_i = 1'b0;
  logic        psel = 1'b0;
  logic        pen = 1'b0;
  logic        pwr = 1'b0;
  logic [7:0]  pad = 8'h00;
  logic [31:0] pwd = 32'h0;
  logic [31:0] q;
  logic        err;
  logic        dis = 1'b0, absent = 1'b0, vin = 1'b0, therm = 1'b0;
  logic        ilim = 1'b0, rbel = 1'b0, izero = 1'b0, taper = 1'b0;
  logic        sag = 1'b0;
  logic [15:0] bat = 16'd2000;
  logic        trk, amin, areg, atop, brch, prdy, perr, irqn, soft_seen;
  logic [31:0] prd;
  logic [7:0]  lim;
  logic [6:0]  st;
  int          n_mismatch = 0;
  int          n_compared = 0;
  always #4 clk_i = ~clk_i;
  always @(posedge clk_i) if (st[SFT] === 1'b1) soft_seen <= 1'b1;
  cts_analog_model u_bat (.bat_mv_i(bat), .taper_i(taper), .trkl_o(trk),
    .min_o(amin), .reg_o(areg), .topoff_o(atop), .rch_o(brch));
  cts_top #(.DEGLITCH_CYC(DGL), .MIN_CYC(100)) dut (
    .clk_i(clk_i), .resetn_i(resetn_i), .psel_i(psel), .penable_i(pen),
    .pwrite_i(pwr), .paddr_i(pad), .pwdata_i(pwd), .prdata_o(prd),
    .pready_o(prdy), .pslverr_o(perr), .charge_disable_pin_i(dis),
    .battery_absent_pin_i(absent), .input_valid_i(vin),
    .input_uvlo_i(1'b0), .input_ovp_i(1'b0), .bat_ovp_i(1'b0),
    .thermal_sd_i(therm), .bat_above_trickle_i(trk),
    .bat_above_min_i(amin), .bat_at_reg_i(areg), .i_at_topoff_i(atop),
    .bat_below_rch_i(brch), .input_sag_i(sag), .ilim_hit_i(ilim),
    .rail_below_bat_i(rbel), .ichg_zero_i(izero), .charge_on_o(st[CHG]),
    .fast_mode_o(st[FST]), .cv_mode_o(st[CV]), .soft_start_o(st[SFT]),
    .rail_boot_o(st[2]), .rail_hold_o(st[1]), .supplement_o(st[SUP]),
    .in_limit_o(lim), .irq_out_n_o(irqn));
  //==============================================================
  // tasks
  task automatic chk(input string nm, input logic [31:0] s, e);
    n_compared++;
    if (s !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  // read data stands during the access cycle and is taken at its edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk_i);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    pad <= a;
    pwd <= d;
    @(posedge clk_i);
    pen <= 1'b1;
    do @(posedge clk_i); while (prdy !== 1'b1);
    err = perr;
    q = prd;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic wait_st(input int k, input logic v, input int n);
    int i;
    i = 0;
    while (st[k] !== v && i < n) begin
      @(posedge clk_i);
      i++;
    end
    chk($sformatf("state bit %0d", k), {31'h0, st[k]}, {31'h0, v});
  endtask
  task automatic test_done;
    if (n_mismatch == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  //==============================================================
  // tests
  initial begin
    repeat (8) @(posedge clk_i);
    resetn_i <= 1'b1;
    apb(1'b0, CTS_CTRL_ADDR, 32'h0);
    chk("ctrl", q, 32'h0000_0f03);
    apb(1'b0, CTS_TIMER_ADDR, 32'h0);
    chk("timer", q, 32'h002d_00b4);
    apb(1'b0, 8'h18, 32'h0);
    chk("unmapped", {err, q[30:0]}, 32'h8000_0000);
    apb(1'b1, CTS_CTRL_ADDR, 32'h0000_0003);
    apb(1'b1, CTS_TIMER_ADDR, 32'h0002_0000);
    apb(1'b1, CTS_LIMIT_ADDR, 32'h0000_0004);
    vin <= 1'b1;
    wait_st(CHG, 1'b1, 40);
    wait_st(2, 1'b1, 10);
    bat <= 16'd3000;
    repeat (10) @(posedge clk_i);
    chk("boot rail", {31'h0, st[2]}, 32'h1);
    bat <= 16'd3700;
    wait_st(SFT, 1'b1, 40);
    wait_st(SFT, 1'b0, 1300);
    chk("fast", {31'h0, st[FST]}, 32'h1);
    // four soft-start ticks of 1250 cycles bring the limit to its cap
    repeat (5000) @(posedge clk_i);
    chk("limit", {24'h0, lim}, 32'h4);
    sag <= 1'b1;
    for (int i = 0; i < 1400 && lim == 8'h04; i++)
      @(posedge clk_i);
    chk("sag down", {24'h0, lim}, 32'h3);
    sag <= 1'b0;
    for (int i = 0; i < 1400 && lim == 8'h03; i++)
      @(posedge clk_i);
    chk("sag up", {24'h0, lim}, 32'h4);
    bat <= 16'd4200;
    taper <= 1'b1;
    wait_st(CV, 1'b1, 100);
    wait_st(CHG, 1'b0, 600);
    apb(1'b0, CTS_IRQ_ADDR, 32'h0);
    chk("irq done", q, 32'h18);
    apb(1'b0, CTS_IRQ_ADDR, 32'h0);
    chk("irq clear", q, 32'h0);
    chk("irq pin", {31'h0, irqn}, 32'h1);
    // a dip shorter than the deglitch window must leave no trace
    bat <= 16'd4050;
    repeat (DGL - 20) @(posedge clk_i);
    bat <= 16'd4200;
    repeat (DGL + 20) @(posedge clk_i);
    chk("no restart", {31'h0, st[CHG]}, 32'h0);
    chk("no event", {31'h0, irqn}, 32'h1);
    soft_seen <= 1'b0;
    taper <= 1'b0;
    bat <= 16'd4050;
    wait_st(CHG, 1'b1, DGL + 20);
    chk("restart fast", {31'h0, st[FST]}, 32'h1);
    chk("no soft", {31'h0, soft_seen}, 32'h0);
    apb(1'b0, CTS_IRQ_ADDR, 32'h0);
    chk("irq recharge", q, 32'h1);
    ilim <= 1'b1;
    rbel <= 1'b1;
    izero <= 1'b1;
    wait_st(SUP, 1'b1, 20);
    chk("rail hold", {31'h0, st[1]}, 32'h1);
    apb(1'b0, CTS_IRQ_ADDR, 32'h0);
    chk("irq overload", q, 32'h20);
    ilim <= 1'b0;
    rbel <= 1'b0;
    izero <= 1'b0;
    absent <= 1'b1;
    wait_st(CHG, 1'b0, 10);
    apb(1'b0, CTS_IRQ_ADDR, 32'h0);
    chk("irq absent", q, 32'h2);
    absent <= 1'b0;
    apb(1'b1, CTS_CTRL_ADDR, 32'h0000_0002);
    apb(1'b1, CTS_CTRL_ADDR, 32'h0000_0003);
    wait_st(CHG, 1'b1, 40);
    dis <= 1'b1;
    wait_st(CHG, 1'b0, 10);
    dis <= 1'b0;
    wait_st(CHG, 1'b1, 40);
    therm <= 1'b1;
    wait_st(CHG, 1'b0, 10);
    therm <= 1'b0;
    test_done();
  end
  initial begin
    repeat (40000) @(posedge clk_i);
    n_mismatch++;
    test_done();
  end
endmodule
bind cts_top cts_top_props u_props (.clk_i(clk_i), .resetn_i(resetn_i),
  .psel_i(psel_i), .charge_disable_pin_i(charge_disable_pin_i),
  .battery_absent_pin_i(battery_absent_pin_i), .thermal_sd_i(thermal_sd_i),
  .ilim_hit_i(ilim_hit_i), .rail_below_bat_i(rail_below_bat_i),
  .charge_on_o(charge_on_o), .fast_mode_o(fast_mode_o),
  .cv_mode_o(cv_mode_o), .rail_boot_o(rail_boot_o),
  .rail_hold_o(rail_hold_o), .supplement_o(supplement_o),
  .in_limit_o(in_limit_o), .irq_out_n_o(irq_out_n_o));
